// ==== core/timer_defs.svh ====
/*
  register offsets, field positions, reset values and divider counts
  of the auto-reload/capture timer; included by the timer core and its bench
*/
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH
// byte addresses on the bus, decoded on haddr[7:0]
`define OFS_CTRL 8'h00
`define OFS_CLKSEL 8'h04
`define OFS_RLD_LO 8'h08
`define OFS_RLD_HI 8'h0c
`define OFS_CNT_LO 8'h10
`define OFS_CNT_HI 8'h14
`define OFS_IRQEN 8'h18
// timer_control_register fields
`define CTL_HOF 7
`define CTL_LOF 6
`define CTL_LIEN 5
`define CTL_CAP 4
`define CTL_SPLIT 3
`define CTL_RUN 2
`define CTL_XCLK_HI 1
`define CTL_XCLK_LO 0
// clock_select_register and extended_irq_enable fields
`define CKS_LOW 0
`define CKS_HIGH 1
`define IEN_TIMER 0
// reset values
`define RST_BYTE 8'h00
`define RST_XCLK 2'h0
// external select encodings
`define XCLK_DIV12 2'h0
`define XCLK_CMP 2'h1
`define XCLK_RSVD 2'h2
`define XCLK_EXT8 2'h3
// dividers: last count of each prescaler
`define DIV12_LAST 4'hb
`define EXT8_LAST 3'h7
// bus and counter constants
`define HSIZE_WORD 3'h2
`define BYTE_MAX 8'hff
`define WORD_MAX 16'hffff
`endif

// ==== core/timer_pkg.sv ====
/*
  types shared by the timer core and its bus port
  assumes the defs header supplies all numeric constants
*/
package timer_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] count_t;
  typedef logic [31:0] word_t;
  typedef logic [1:0] xclk_t;
  // resolved clock source of one counter byte
  typedef enum logic [2:0] {
    src_sys,
    src_div12,
    src_cmp,
    src_ext8,
    src_none
  } clk_src_t;
endpackage

// ==== core/edge_sync.sv ====
/*
  two-flop synchroniser with a rising-edge pulse
  assumes raw_in may be asynchronous to clock_in
*/
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic raw_in,
  output var logic rise_out
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  // meta_r feeds sync_r only
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= raw_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // one-cycle pulse per synchronised rising edge
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rise_out <= 1'b0;
    end else begin
      rise_out <= sync_r & ~last_r;
    end
  end

  a_rise_single: assert property (
    @(posedge clock_in) disable iff (!rst_n_in)
    rise_out |=> !rise_out)
    else $error("edge pulse longer than one cycle");
endmodule // edge_sync
`default_nettype wire

// ==== core/auto_reload_capture_timer.sv ====
/*
  16-bit auto-reload / dual 8-bit / capture timer with an AHB-Lite
  register slave. assumes one AHB-Lite master, zero-wait slave,
  comparator and oscillator inputs asynchronous to clock_in.
*/
// Implementation choices: the placing of the registers and register access over AHB-Lite.
// Operation
// - two bytes form one 16-bit count
// - sources: sysclk, sysclk/12, ext/8, comparator
// - ext and comparator synchronised before use
// - 16-bit wrap reloads and sets high flag, capture off
// - 16-bit overflow interrupts when enabled, capture off
// - low byte wrap interrupts with low enable
// - split: two bytes reload independently
// - split: run gates high byte only
// - per-byte sysclk select, else external field
// - split: each byte wrap sets its flag
// - split interrupts: high, or low with low enable
// - flags cleared only by software
// - external field bit one picks trigger
// - capture copies count, sets high flag
// - capture counts on sysclk or sysclk/12
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"
module auto_reload_capture_timer (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire timer_pkg::word_t haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire timer_pkg::word_t hwdata_in,
  input wire logic hready_in,
  input wire logic comparator_in,
  input wire logic ext_osc_in,
  output var timer_pkg::word_t hrdata_out,
  output var logic hreadyout_out,
  output var logic hresp_out,
  output var logic irq_req_out
);
  import timer_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // register state
  byte_t count_low_byte_r;
  byte_t count_high_byte_r;
  byte_t reload_low_byte_r;
  byte_t reload_high_byte_r;
  logic high_overflow_flag_r;
  logic low_overflow_flag_r;
  logic low_byte_irq_enable_r;
  logic capture_mode_enable_r;
  logic split_mode_select_r;
  logic run_control_bit_r;
  xclk_t external_clock_select_r;
  logic high_byte_sysclk_select_r;
  logic low_byte_sysclk_select_r;
  logic timer_irq_enable_r;

  // bus pipeline
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  word_t rd_mux;
  logic addr_take;
  logic wr_ctrl, wr_cks, wr_ien;
  logic wr_rlo, wr_rhi, wr_clo, wr_chi;

  // clock sources
  logic [3:0] div12_cnt_r;
  logic [2:0] ext8_cnt_r;
  logic tick_div12, tick_ext8, cmp_rise, ext_rise;
  clk_src_t low_src, high_src, cap_src;
  logic low_tick, high_tick, tick16, cap_trig, cap_evt;
  logic wrap16, low_roll, high_set;
  count_t count16;

  ////////////////////////////////////////////////////////////////////
  // bus slave: address phase taken on hready, write in data phase
  assign addr_take = hsel_in & hready_in & htrans_in[1];

  // latch write address; non-word writes are dropped
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= `RST_BYTE;
    end else begin
      wr_pend_r <= addr_take & hwrite_in & (hsize_in == `HSIZE_WORD);
      wr_addr_r <= haddr_in[7:0];
    end
  end

  // data-phase write strobes
  assign wr_ctrl = wr_pend_r & (wr_addr_r == `OFS_CTRL);
  assign wr_cks = wr_pend_r & (wr_addr_r == `OFS_CLKSEL);
  assign wr_ien = wr_pend_r & (wr_addr_r == `OFS_IRQEN);
  assign wr_rlo = wr_pend_r & (wr_addr_r == `OFS_RLD_LO);
  assign wr_rhi = wr_pend_r & (wr_addr_r == `OFS_RLD_HI);
  assign wr_clo = wr_pend_r & (wr_addr_r == `OFS_CNT_LO);
  assign wr_chi = wr_pend_r & (wr_addr_r == `OFS_CNT_HI);

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr_in[7:0])
      `OFS_CTRL: rd_mux[7:0] = {high_overflow_flag_r,
                                low_overflow_flag_r,
                                low_byte_irq_enable_r,
                                capture_mode_enable_r,
                                split_mode_select_r,
                                run_control_bit_r,
                                external_clock_select_r};
      `OFS_CLKSEL: begin
        rd_mux[`CKS_LOW] = low_byte_sysclk_select_r;
        rd_mux[`CKS_HIGH] = high_byte_sysclk_select_r;
      end
      `OFS_IRQEN: rd_mux[`IEN_TIMER] = timer_irq_enable_r;
      `OFS_RLD_LO: rd_mux[7:0] = reload_low_byte_r;
      `OFS_RLD_HI: rd_mux[7:0] = reload_high_byte_r;
      `OFS_CNT_LO: rd_mux[7:0] = count_low_byte_r;
      `OFS_CNT_HI: rd_mux[7:0] = count_high_byte_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data sampled at the address phase, stands in the data phase
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (addr_take & ~hwrite_in) begin
      hrdata_out <= rd_mux;
    end
  end

  // zero-wait, always OKAY
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_byte_irq_enable_r <= 1'b0;
      capture_mode_enable_r <= 1'b0;
      split_mode_select_r <= 1'b0;
      run_control_bit_r <= 1'b0;
      external_clock_select_r <= `RST_XCLK;
    end else if (wr_ctrl) begin
      low_byte_irq_enable_r <= hwdata_in[`CTL_LIEN];
      capture_mode_enable_r <= hwdata_in[`CTL_CAP];
      split_mode_select_r <= hwdata_in[`CTL_SPLIT];
      run_control_bit_r <= hwdata_in[`CTL_RUN];
      external_clock_select_r <= hwdata_in[`CTL_XCLK_HI:`CTL_XCLK_LO];
    end
  end

  // per-byte sysclk selects and the timer interrupt enable
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_byte_sysclk_select_r <= 1'b0;
      high_byte_sysclk_select_r <= 1'b0;
      timer_irq_enable_r <= 1'b0;
    end else begin
      if (wr_cks) begin
        low_byte_sysclk_select_r <= hwdata_in[`CKS_LOW];
        high_byte_sysclk_select_r <= hwdata_in[`CKS_HIGH];
      end
      if (wr_ien) begin
        timer_irq_enable_r <= hwdata_in[`IEN_TIMER];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // clock sources
  edge_sync u_cmp_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .raw_in(comparator_in),
    .rise_out(cmp_rise)
  );

  edge_sync u_ext_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .raw_in(ext_osc_in),
    .rise_out(ext_rise)
  );

  // free-running prescalers; ext/8 counts synchronised edges only
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div12_cnt_r <= 4'h0;
      ext8_cnt_r <= 3'h0;
    end else begin
      div12_cnt_r <= tick_div12 ? 4'h0 : div12_cnt_r + 4'h1;
      if (ext_rise) begin
        ext8_cnt_r <= ext8_cnt_r + 3'h1;
      end
    end
  end

  assign tick_div12 = (div12_cnt_r == `DIV12_LAST);
  assign tick_ext8 = ext_rise & (ext8_cnt_r == `EXT8_LAST);

  // resolve one byte's source
  function automatic clk_src_t src_of(input logic sys_sel,
                                      input xclk_t xsel);
    clk_src_t s;
    s = src_none;
    if (sys_sel) begin
      s = src_sys;
    end else begin
      unique case (xsel)
        `XCLK_DIV12: s = src_div12;
        `XCLK_CMP: s = src_cmp;
        `XCLK_RSVD: s = src_none;
        `XCLK_EXT8: s = src_ext8;
      endcase
    end
    return s;
  endfunction

  // tick of a resolved source; reserved never ticks
  function automatic logic tick_of(input clk_src_t s, input logic d12,
                                   input logic cmp, input logic e8);
    logic t;
    t = 1'b0;
    unique case (s)
      src_sys: t = 1'b1;
      src_div12: t = d12;
      src_cmp: t = cmp;
      src_ext8: t = e8;
      src_none: t = 1'b0;
    endcase
    return t;
  endfunction

  assign low_src = src_of(low_byte_sysclk_select_r,
                          external_clock_select_r);
  assign high_src = src_of(high_byte_sysclk_select_r,
                           external_clock_select_r);
  // capture counts on sysclk or sysclk/12 only
  assign cap_src = low_byte_sysclk_select_r ? src_sys : src_div12;

  ////////////////////////////////////////////////////////////////////
  // count enables
  assign count16 = {count_high_byte_r, count_low_byte_r};
  assign low_tick = tick_of(low_src, tick_div12, cmp_rise,
                            tick_ext8);
  assign high_tick = run_control_bit_r &
                     tick_of(high_src, tick_div12, cmp_rise,
                             tick_ext8);
  assign tick16 = run_control_bit_r & (capture_mode_enable_r ?
                  tick_of(cap_src, tick_div12, cmp_rise, tick_ext8) :
                  low_tick);
  // trigger: comparator edge, or every 8 external clocks
  assign cap_trig = external_clock_select_r[1] ? tick_ext8 :
                    cmp_rise;
  assign cap_evt = capture_mode_enable_r & cap_trig;
  assign wrap16 = tick16 & (count16 == `WORD_MAX);

  // flag set terms, either mode
  assign low_roll = (split_mode_select_r ? low_tick : tick16) &
                    (count_low_byte_r == `BYTE_MAX);
  assign high_set = split_mode_select_r ?
                    (high_tick & (count_high_byte_r == `BYTE_MAX)) :
                    (wrap16 & ~capture_mode_enable_r);

  ////////////////////////////////////////////////////////////////////
  // low byte: software write beats counting in the same cycle
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_low_byte_r <= `RST_BYTE;
    end else if (wr_clo) begin
      count_low_byte_r <= hwdata_in[7:0];
    end else if (split_mode_select_r) begin
      if (low_tick) begin
        count_low_byte_r <= (count_low_byte_r == `BYTE_MAX) ?
                            reload_low_byte_r :
                            count_low_byte_r + 8'h01;
      end
    end else if (tick16) begin
      if (wrap16) begin
        // capture mode wraps to zero; reload holds the capture
        count_low_byte_r <= capture_mode_enable_r ? `RST_BYTE :
                            reload_low_byte_r;
      end else begin
        count_low_byte_r <= count_low_byte_r + 8'h01;
      end
    end
  end

  // high byte
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_high_byte_r <= `RST_BYTE;
    end else if (wr_chi) begin
      count_high_byte_r <= hwdata_in[7:0];
    end else if (split_mode_select_r) begin
      if (high_tick) begin
        count_high_byte_r <= (count_high_byte_r == `BYTE_MAX) ?
                             reload_high_byte_r :
                             count_high_byte_r + 8'h01;
      end
    end else if (tick16) begin
      if (wrap16) begin
        count_high_byte_r <= capture_mode_enable_r ? `RST_BYTE :
                             reload_high_byte_r;
      end else if (count_low_byte_r == `BYTE_MAX) begin
        count_high_byte_r <= count_high_byte_r + 8'h01;
      end
    end
  end

  // reload bytes; a capture wins over a write in the same cycle
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reload_low_byte_r <= `RST_BYTE;
      reload_high_byte_r <= `RST_BYTE;
    end else if (cap_evt) begin
      reload_low_byte_r <= count_low_byte_r;
      reload_high_byte_r <= count_high_byte_r;
    end else begin
      if (wr_rlo) begin
        reload_low_byte_r <= hwdata_in[7:0];
      end
      if (wr_rhi) begin
        reload_high_byte_r <= hwdata_in[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sticky flags: hardware set beats a software clear
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      high_overflow_flag_r <= 1'b0;
      low_overflow_flag_r <= 1'b0;
    end else begin
      high_overflow_flag_r <= (high_set | cap_evt) |
                              (wr_ctrl ? hwdata_in[`CTL_HOF] :
                               high_overflow_flag_r);
      low_overflow_flag_r <= low_roll |
                             (wr_ctrl ? hwdata_in[`CTL_LOF] :
                              low_overflow_flag_r);
    end
  end

  // request level; software reads both flags to find the source
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_req_out <= 1'b0;
    end else begin
      irq_req_out <= timer_irq_enable_r &
                     (high_overflow_flag_r |
                      (low_byte_irq_enable_r &
                       low_overflow_flag_r));
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  a_high_flag_sticky: assert property (
    high_overflow_flag_r & !wr_ctrl |=> high_overflow_flag_r)
    else $error("high flag cleared by hardware");

  a_low_flag_sticky: assert property (
    low_overflow_flag_r & !wr_ctrl |=> low_overflow_flag_r)
    else $error("low flag cleared by hardware");

  a_wrap_reload16: assert property (
    !split_mode_select_r & !capture_mode_enable_r & wrap16 &
    !wr_pend_r |=> count16 == $past({reload_high_byte_r,
    reload_low_byte_r}) && high_overflow_flag_r)
    else $error("16-bit wrap did not reload");

  a_incr16_step: assert property (
    !split_mode_select_r & !wr_pend_r & !wrap16 &
    run_control_bit_r & tick16 |=> count16 == $past(count16) + 16'h1)
    else $error("16-bit count did not step");

  a_stop_holds: assert property (
    !split_mode_select_r & !run_control_bit_r & !wr_pend_r
    |=> $stable(count16))
    else $error("stopped counter moved");

  a_split_high_gated: assert property (
    split_mode_select_r & !run_control_bit_r & !wr_pend_r
    |=> $stable(count_high_byte_r))
    else $error("high byte ran while stopped");

  a_split_low_runs: assert property (
    split_mode_select_r & !run_control_bit_r &
    low_byte_sysclk_select_r & !wr_pend_r &
    count_low_byte_r != `BYTE_MAX
    |=> count_low_byte_r == $past(count_low_byte_r) + 8'h01)
    else $error("low byte did not run in split mode");

  a_split_low_wrap: assert property (
    split_mode_select_r & low_tick & !wr_pend_r &
    count_low_byte_r == `BYTE_MAX
    |=> count_low_byte_r == $past(reload_low_byte_r) &&
    low_overflow_flag_r)
    else $error("low byte wrap wrong");

  a_split_high_sys: assert property (
    split_mode_select_r & run_control_bit_r &
    high_byte_sysclk_select_r & !wr_pend_r &
    count_high_byte_r != `BYTE_MAX
    |=> count_high_byte_r == $past(count_high_byte_r) + 8'h01)
    else $error("high byte ignored sysclk select");

  // both split and 16-bit mode: the low byte must not move
  a_reserved_hold: assert property (
    !capture_mode_enable_r & !low_byte_sysclk_select_r &
    external_clock_select_r == `XCLK_RSVD & !wr_pend_r
    |=> $stable(count_low_byte_r))
    else $error("reserved source advanced the low byte");

  a_capture_copy: assert property (
    cap_evt |=> {reload_high_byte_r, reload_low_byte_r} ==
    $past(count16) && high_overflow_flag_r)
    else $error("capture did not copy count");

  a_irq_follow: assert property (
    timer_irq_enable_r & high_overflow_flag_r & !wr_pend_r
    |=> irq_req_out)
    else $error("overflow did not request interrupt");

  a_div12_space: assert property (
    tick_div12 |=> !tick_div12 [*8])
    else $error("sysclk/12 tick too close");

  c_wrap16: cover property (wrap16 & !split_mode_select_r);
  c_split_low: cover property (split_mode_select_r & low_roll);
  c_capture: cover property (cap_evt);
  c_irq: cover property ($rose(irq_req_out));
endmodule // auto_reload_capture_timer
`default_nettype wire

// ==== bench/auto_reload_capture_timer_bench.sv ====
/*
  self-checking bench of the auto-reload/capture timer: bus tasks and
  one task per scenario. assumes the core files and the defs header
  are on the include path and the slave answers with zero waits.
*/
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"
module auto_reload_capture_timer_bench;
  import timer_pkg::*;
  logic clock_in, rst_n_in, hsel, hwrite, cmp, osc, hready, hresp, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  word_t haddr, hwdata, hrdata;
  int n_mismatch = 0;
  int cmp_count = 0;

  auto_reload_capture_timer uut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .comparator_in(cmp), .ext_osc_in(osc), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .irq_req_out(irq)
  );

  // 10 MHz system clock
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input word_t seen, input word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // bounded wait for hready high at a rising edge
  task automatic edge_ready;
    int k;
    k = 0;
    do begin
      @(posedge clock_in);
      k++;
    end while (hready !== 1'b1 && k < 40);
    if (hready !== 1'b1) begin
      check("hready", {31'h0, hready}, 32'h1);
      end_sim();
    end
  endtask

  // one single word transfer; one idle first so a read-back sees the write
  task automatic bus(input logic w, input byte_t a, input word_t wd,
                     output word_t rd);
    @(posedge clock_in);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= `HSIZE_WORD;
    edge_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    edge_ready();
    rd = hrdata;
  endtask

  task automatic wr(input byte_t a, input byte_t d);
    word_t t;
    bus(1'b1, a, {24'h0, d}, t);
  endtask

  task automatic rd(input byte_t a, output byte_t d);
    word_t t;
    bus(1'b0, a, 32'h0, t);
    check("upper bits", {8'h0, t[31:8]}, 32'h0);
    check("hresp", {31'h0, hresp}, 32'h0);
    d = t[7:0];
  endtask

  task automatic exp_reg(input string what, input byte_t a, input byte_t e);
    byte_t d;
    rd(a, d);
    check(what, {24'h0, d}, {24'h0, e});
  endtask

  task automatic exp_rng(input string what, input byte_t a, input byte_t lo,
                         input byte_t hi);
    byte_t d;
    rd(a, d);
    check(what, {31'h0, (d >= lo && d <= hi)}, 32'h1);
  endtask

  task automatic exp_irq(input logic e);
    check("irq", {31'h0, irq}, {31'h0, e});
  endtask

  // slow rising edges so the synchroniser sees every one
  task automatic pulse(input logic ext, input int n);
    repeat (n) begin
      @(posedge clock_in);
      if (ext) osc <= 1'b1;
      else cmp <= 1'b1;
      repeat (3) @(posedge clock_in);
      if (ext) osc <= 1'b0;
      else cmp <= 1'b0;
      repeat (2) @(posedge clock_in);
    end
    repeat (6) @(posedge clock_in);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int a = 0; a <= 28; a += 4) exp_reg("reset", byte_t'(a), 8'h00);
    $display("test reset done");
  endtask

  task automatic t_wide;
    byte_t d;
    wr(`OFS_CNT_LO, 8'hf0);
    wr(`OFS_CNT_HI, 8'hff);
    wr(`OFS_RLD_LO, 8'hcd);
    wr(`OFS_RLD_HI, 8'hab);
    wr(`OFS_CLKSEL, 8'h01);
    wr(`OFS_IRQEN, 8'h01);
    wr(`OFS_CTRL, 8'h04);
    repeat (40) @(posedge clock_in);
    exp_reg("cnt hi reload", `OFS_CNT_HI, 8'hab);
    rd(`OFS_CTRL, d);
    check("high flag", {31'h0, d[7]}, 32'h1);
    exp_irq(1'b1);
    repeat (30) @(posedge clock_in);
    rd(`OFS_CTRL, d);
    check("flag sticky", {31'h0, d[7]}, 32'h1);
    wr(`OFS_CNT_HI, 8'h00);
    wr(`OFS_CNT_LO, 8'hf8);
    wr(`OFS_CTRL, 8'h24);
    repeat (20) @(posedge clock_in);
    rd(`OFS_CTRL, d);
    check("low wrap flags", {30'h0, d[7:6]}, 32'h1);
    exp_irq(1'b1);
    wr(`OFS_CTRL, 8'h00);
    repeat (3) @(posedge clock_in);
    exp_irq(1'b0);
    $display("test wide done");
  endtask

  task automatic t_split;
    byte_t d;
    wr(`OFS_CNT_LO, 8'hfe);
    wr(`OFS_RLD_LO, 8'h40);
    wr(`OFS_CNT_HI, 8'h10);
    wr(`OFS_CTRL, 8'h08);
    repeat (10) @(posedge clock_in);
    rd(`OFS_CTRL, d);
    check("split low flag", {30'h0, d[7:6]}, 32'h1);
    exp_irq(1'b0);
    exp_reg("high held", `OFS_CNT_HI, 8'h10);
    exp_rng("low reload", `OFS_CNT_LO, 8'h40, 8'h60);
    wr(`OFS_CTRL, 8'h68);
    repeat (3) @(posedge clock_in);
    exp_irq(1'b1);
    wr(`OFS_CNT_HI, 8'hfe);
    wr(`OFS_RLD_HI, 8'h77);
    wr(`OFS_CLKSEL, 8'h03);
    wr(`OFS_CTRL, 8'h0c);
    repeat (10) @(posedge clock_in);
    rd(`OFS_CTRL, d);
    check("split high flag", {31'h0, d[7]}, 32'h1);
    exp_rng("high reload", `OFS_CNT_HI, 8'h77, 8'h90);
    exp_irq(1'b1);
    wr(`OFS_CTRL, 8'h00);
    $display("test split done");
  endtask

  task automatic t_sources;
    wr(`OFS_CLKSEL, 8'h00);
    wr(`OFS_CNT_LO, 8'h00);
    wr(`OFS_CNT_HI, 8'h00);
    wr(`OFS_CTRL, 8'h06);
    repeat (50) @(posedge clock_in);
    exp_reg("reserved holds", `OFS_CNT_LO, 8'h00);
    wr(`OFS_CTRL, 8'h04);
    repeat (120) @(posedge clock_in);
    wr(`OFS_CTRL, 8'h00);
    exp_rng("div12", `OFS_CNT_LO, 8'h0a, 8'h0b);
    wr(`OFS_CNT_LO, 8'h00);
    wr(`OFS_CTRL, 8'h05);
    pulse(1'b0, 5);
    exp_reg("comparator", `OFS_CNT_LO, 8'h05);
    wr(`OFS_CNT_LO, 8'h00);
    wr(`OFS_CTRL, 8'h07);
    pulse(1'b1, 16);
    exp_reg("ext div8", `OFS_CNT_LO, 8'h02);
    wr(`OFS_CTRL, 8'h00);
    $display("test sources done");
  endtask

  task automatic t_capture;
    byte_t d;
    byte_t lo, hi, d2;
    count_t gap;
    wr(`OFS_CNT_LO, 8'h34);
    wr(`OFS_CNT_HI, 8'h12);
    wr(`OFS_CTRL, 8'h10);
    pulse(1'b0, 1);
    exp_reg("cap cmp lo", `OFS_RLD_LO, 8'h34);
    exp_reg("cap cmp hi", `OFS_RLD_HI, 8'h12);
    rd(`OFS_CTRL, d);
    check("cap flag", {31'h0, d[7]}, 32'h1);
    exp_irq(1'b1);
    wr(`OFS_CNT_LO, 8'h78);
    wr(`OFS_CNT_HI, 8'h56);
    wr(`OFS_CTRL, 8'h12);
    pulse(1'b1, 8);
    exp_reg("cap ext lo", `OFS_RLD_LO, 8'h78);
    exp_reg("cap ext hi", `OFS_RLD_HI, 8'h56);
    rd(`OFS_CTRL, d);
    check("cap ext flag", {31'h0, d[7]}, 32'h1);
    // two comparator edges 18 clocks apart, counted on sysclk:
    // the difference of the captures is that spacing
    wr(`OFS_CLKSEL, 8'h01);
    wr(`OFS_CTRL, 8'h14);
    pulse(1'b0, 1);
    rd(`OFS_RLD_LO, lo);
    rd(`OFS_RLD_HI, hi);
    pulse(1'b0, 1);
    rd(`OFS_RLD_LO, d);
    rd(`OFS_RLD_HI, d2);
    gap = {d2, d} - {hi, lo};
    check("capture period", {16'h0, gap}, 32'h12);
    wr(`OFS_CTRL, 8'h00);
    $display("test capture done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // reset for ten cycles, then the scenarios in turn
  initial begin
    rst_n_in = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = `HSIZE_WORD;
    hwdata = 32'h0;
    cmp = 1'b0;
    osc = 1'b0;
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_wide();
    t_split();
    t_sources();
    t_capture();
    end_sim();
  end
endmodule // auto_reload_capture_timer_bench
`default_nettype wire
